// file: sfpc_control.sv
// Operation
// - Signature read armed, a load within three cycles returns a signature byte.
// - Store within four cycles of signature arming does nothing.
// - Writing clear-buffer discards the whole temporary page buffer; a word loaded in the same cycle is kept.
// - Fuse/lock read armed, a load within three cycles returns fuse or lock byte.
// - Page write armed, a store within four cycles programs buffer into pointer page.
// - Page erase armed, a store within four cycles erases the pointer page.
// - Page write and erase bits clear on completion or after four idle cycles.
// - Processor is stalled for the whole page write or erase.
// - Enable alone, a store puts the data word into buffer at pointer word if that word is still empty.
// - Enable clears after a store or four idle cycles, held during page operations.
// - Control writes with an illegal low six-bit pattern are ignored.
// - An EEPROM write blocks programming and fuse/lock readback.
// - Lock read at pointer one returns both lock bits in bits 1 and 0.
// - Fuse/lock arming clears after the read or after three idle cycles.
// - Fuse low at 0, high at 3, extended at 2 using bit 0 only.
// - Programmed fuse and lock bits read zero, unprogrammed read one.
// - Signature bytes at 0, 2, 4, calibration at 1, temperature trims at 3, 5.
// - Signature arming clears after the read or three cycles without a load.
// - Loads address flash bytes, pointer LSB selecting the byte in a word.
// - Control bits 7 and 6 always read zero.
// - The buffer is erased after page write, on clear-buffer and on reset; clear-buffer keeps a word loaded in the same cycle.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sfpc_control import sfpc_pkg::*; #(
  // Identity bytes; the values are arbitrary.
  parameter logic [7:0] SIG_BYTE0 = 8'h11,
  parameter logic [7:0] SIG_BYTE1 = 8'h22,
  parameter logic [7:0] SIG_BYTE2 = 8'h33
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic spm_strobe,
  input wire logic lpm_strobe,
  input wire logic [7:0] pointer_high_byte,
  input wire logic [7:0] pointer_low_byte,
  input wire logic [15:0] store_data,
  output logic lpm_special,
  output logic [7:0] lpm_data,
  output logic cpu_stall,
  input wire logic eeprom_write_busy,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic fuse_extended_byte,
  input wire logic lock_bit_one,
  input wire logic lock_bit_two,
  input wire logic [7:0] osc_cal_byte,
  input wire logic [7:0] temp_sensor_offset,
  input wire logic [7:0] temp_sensor_gain,
  output logic flash_erase_req,
  output logic flash_write_req,
  output logic [PAGE_W-1:0] flash_page,
  input wire logic flash_done,
  input wire logic [WADDR_W-1:0] buf_rd_addr,
  output logic [15:0] buf_rd_data
);
  sfpc_regs_t s;
  sfpc_regs_t n;
  logic [PTR_W-1:0] pointer;
  logic [WADDR_W-1:0] widx;
  logic armed;
  logic [2:0] lim;
  logic do_write;
  logic ctl_wr;
  logic buf_we;
  logic [15:0] mem_q;
  logic [7:0] sig_now;
  logic [1:0] lock_now;
  logic [PAGE_W-1:0] ptr_page;

  assign pointer = {pointer_high_byte, pointer_low_byte};
  assign widx = pointer[PAGE_LSB-1:WORD_LSB];

  assign awready = ce && !s.aw_got && !s.bvalid;
  assign wready = ce && !s.w_got && !s.bvalid;
  assign arready = ce && !s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = {24'h000000, s.rdata};
  assign lpm_special = s.lpm_valid;
  assign lpm_data = s.lpm_data;
  assign cpu_stall = (s.state == SFPC_BUSY);
  assign flash_erase_req = s.erase_req;
  assign flash_write_req = s.write_req;
  assign flash_page = s.page;
  assign buf_rd_data = s.rd_ok ? mem_q : ERASED_WORD;

  function automatic logic [7:0] fuse_byte(input logic [PTR_W-1:0] p);
    unique case (p)
      FUSE_LOW_ADDR: return fuse_low_byte;
      LOCK_ADDR: return {LOCK_PAD, lock_bit_two, lock_bit_one};
      FUSE_EXT_ADDR: return {EXT_PAD, fuse_extended_byte};
      FUSE_HIGH_ADDR: return fuse_high_byte;
      default: return UNPROG_BYTE;
    endcase
  endfunction

  function automatic logic [7:0] sig_byte(input logic [PTR_W-1:0] p);
    unique case (p)
      SIG0_ADDR: return SIG_BYTE0;
      OSC_CAL_ADDR: return osc_cal_byte;
      SIG1_ADDR: return SIG_BYTE1;
      TS_OFFSET_ADDR: return temp_sensor_offset;
      SIG2_ADDR: return SIG_BYTE2;
      TS_GAIN_ADDR: return temp_sensor_gain;
      default: return RESERVED_BYTE;
    endcase
  endfunction

  always_comb begin
    n = s;
    n.lpm_valid = 1'b0;
    n.erase_req = 1'b0;
    n.write_req = 1'b0;
    buf_we = 1'b0;
    n.rd_ok = s.valid[buf_rd_addr];
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (awvalid && awready) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      n.w_got = 1'b1;
      n.wbyte = wdata[7:0];
      n.wlane = wstrb[0];
    end
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rdata = (araddr == CTL_ADDR) ? {2'h0, s.ctl} : RESERVED_BYTE;
      n.rresp = (araddr == CTL_ADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    do_write = s.aw_got && s.w_got && !s.bvalid;
    ctl_wr = do_write && (s.awaddr == CTL_ADDR) && s.wlane && (s.state == SFPC_IDLE) &&
             !eeprom_write_busy && sfpc_legal(s.wbyte[CTL_W-1:0]);
    if (do_write) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (s.awaddr == CTL_ADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    armed = (s.state == SFPC_IDLE) && s.ctl[EN_BIT];
    lim = (s.ctl[SG_BIT] || s.ctl[RF_BIT]) ? LPM_WIN : SPM_WIN;
    unique case (s.state)
      SFPC_IDLE: begin
        if (armed) begin
          n.cnt = s.cnt + 3'h1;
          if (s.cnt == lim) begin
            n.ctl = '0;
          end
          if (lpm_strobe && s.ctl[SG_BIT]) begin
            n.lpm_valid = 1'b1;
            n.lpm_data = sig_byte(pointer);
            n.ctl = '0;
          end else if (lpm_strobe && s.ctl[RF_BIT] && !eeprom_write_busy) begin
            n.lpm_valid = 1'b1;
            n.lpm_data = fuse_byte(pointer);
            n.ctl = '0;
          end
          if (spm_strobe && !eeprom_write_busy && !s.ctl[SG_BIT]) begin
            if (s.ctl[PW_BIT] || s.ctl[PE_BIT]) begin
              n.state = SFPC_BUSY;
              n.op_write = s.ctl[PW_BIT];
              n.write_req = s.ctl[PW_BIT];
              n.erase_req = s.ctl[PE_BIT];
              n.page = pointer[PTR_W-1:PAGE_LSB];
              n.ctl = s.ctl;
            end else begin
              if (s.ctl == PAT_EN && !s.valid[widx]) begin
                buf_we = 1'b1;
                n.valid[widx] = 1'b1;
              end
              n.ctl = '0;
            end
          end
        end
      end
      SFPC_BUSY: begin
        if (flash_done) begin
          n.state = SFPC_IDLE;
          n.ctl = '0;
          if (s.op_write) begin
            n.valid = '0;
          end
        end
      end
    endcase
    if (ctl_wr) begin
      n.ctl = s.wbyte[CTL_W-1:0];
      n.cnt = CNT_START;
      if (s.wbyte[CB_BIT]) begin
        n.valid = '0;
        if (buf_we) begin
          n.valid[widx] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  sfpc_page_buffer u_buf (
    .aclk(aclk),
    .ce(ce),
    .we(buf_we),
    .waddr(widx),
    .wdata(store_data),
    .raddr(buf_rd_addr),
    .rdata(mem_q)
  );

  assign sig_now = sig_byte(pointer);
  assign lock_now = {lock_bit_two, lock_bit_one};
  assign ptr_page = pointer[PTR_W-1:PAGE_LSB];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sig_read;
    ce && armed && lpm_strobe && s.ctl == PAT_SIG && !ctl_wr
      |=> lpm_special && lpm_data == $past(sig_now) && s.ctl == '0;
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature load not served");

  property p_sig_store;
    ce && spm_strobe && s.ctl == PAT_SIG && !ctl_wr
      |=> $stable(s.valid) && !flash_write_req && !flash_erase_req;
  endproperty
  a_sig_store: assert property (p_sig_store) else $error("store acted under signature");

  property p_clear;
    ce && ctl_wr && !buf_we && s.wbyte[CTL_W-1:0] == PAT_CLEAR_PAGE_BUFFER |=> s.valid == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("buffer not cleared");

  property p_clear_set;
    ce && ctl_wr && buf_we && s.wbyte[CTL_W-1:0] == PAT_CLEAR_PAGE_BUFFER |=> $countones(s.valid) == 1;
  endproperty
  a_clear_set: assert property (p_clear_set) else $error("store lost to clear");

  property p_lock;
    ce && armed && lpm_strobe && s.ctl == PAT_FLB && pointer == LOCK_ADDR &&
      !eeprom_write_busy && !ctl_wr
      |=> lpm_special && lpm_data[1:0] == $past(lock_now);
  endproperty
  a_lock: assert property (p_lock) else $error("lock bits wrong");

  property p_page_write;
    ce && armed && spm_strobe && s.ctl == PAT_PW && !eeprom_write_busy
      |=> flash_write_req && cpu_stall && flash_page == $past(ptr_page);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write not started");

  property p_erase;
    ce && armed && spm_strobe && s.ctl == PAT_PE && !eeprom_write_busy
      |=> flash_erase_req && !flash_write_req && cpu_stall && flash_page == $past(ptr_page);
  endproperty
  a_erase: assert property (p_erase) else $error("page erase not started");

  property p_busy;
    s.state == SFPC_BUSY |-> cpu_stall && s.ctl[EN_BIT];
  endproperty
  a_busy: assert property (p_busy) else $error("enable dropped while busy");

  property p_window;
    s.state == SFPC_IDLE && s.ctl != '0 |-> s.cnt >= CNT_START && s.cnt <= lim;
  endproperty
  a_window: assert property (p_window) else $error("arming window overrun");

  property p_illegal;
    ce && do_write && s.ctl == '0 && !sfpc_legal(s.wbyte[CTL_W-1:0]) |=> s.ctl == '0;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal pattern accepted");

  property p_eeprom;
    ce && do_write && s.ctl == '0 && eeprom_write_busy |=> s.ctl == '0;
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("write during eeprom busy");

  property p_done;
    ce && s.state == SFPC_BUSY && s.op_write && flash_done && !ctl_wr
      |=> s.valid == '0 && !cpu_stall ##1 buf_rd_data == ERASED_WORD;
  endproperty
  a_done: assert property (p_done) else $error("buffer kept after write");

  property p_reserved;
    rvalid |-> rdata[7:6] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_fuse_high;
    ce && armed && lpm_strobe && s.ctl == PAT_FLB && pointer == FUSE_HIGH_ADDR &&
      !eeprom_write_busy && !ctl_wr
      |=> lpm_special && lpm_data == $past(fuse_high_byte);
  endproperty
  a_fuse_high: assert property (p_fuse_high) else $error("fuse high byte wrong");

  property p_sig_expire;
    ce && armed && s.ctl[SG_BIT] && s.cnt == LPM_WIN && !lpm_strobe && !ctl_wr
      |=> s.ctl == '0;
  endproperty
  a_sig_expire: assert property (p_sig_expire) else $error("signature arming kept");

  property p_load;
    ce && armed && spm_strobe && s.ctl == PAT_EN && !eeprom_write_busy && !ctl_wr
      |=> s.valid[$past(widx)] && s.ctl == '0;
  endproperty
  a_load: assert property (p_load) else $error("buffer word not loaded");

  property p_fuse_eeprom;
    ce && lpm_strobe && eeprom_write_busy && !s.ctl[SG_BIT] |=> !lpm_special;
  endproperty
  a_fuse_eeprom: assert property (p_fuse_eeprom) else $error("fuse read while busy");
endmodule
`default_nettype wire

// file: sfpc_pkg.sv
`default_nettype none
package sfpc_pkg;
  localparam int PTR_W = 16;
  localparam int WORD_LSB = 1;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_W = PTR_W - PAGE_LSB;
  localparam int WADDR_W = PAGE_LSB - WORD_LSB;
  localparam int PAGE_WORDS = 1 << WADDR_W;
  localparam int CTL_W = 6;

  localparam logic [7:0] CTL_ADDR = 8'h00;
  localparam int EN_BIT = 0;
  localparam int PE_BIT = 1;
  localparam int PW_BIT = 2;
  localparam int RF_BIT = 3;
  localparam int CB_BIT = 4;
  localparam int SG_BIT = 5;

  localparam logic [CTL_W-1:0] PAT_SIG = 6'h21;
  localparam logic [CTL_W-1:0] PAT_CLEAR_PAGE_BUFFER = 6'h11;
  localparam logic [CTL_W-1:0] PAT_FLB = 6'h09;
  localparam logic [CTL_W-1:0] PAT_PW = 6'h05;
  localparam logic [CTL_W-1:0] PAT_PE = 6'h03;
  localparam logic [CTL_W-1:0] PAT_EN = 6'h01;

  localparam logic [2:0] LPM_WIN = 3'h3;
  localparam logic [2:0] SPM_WIN = 3'h4;
  localparam logic [2:0] CNT_START = 3'h1;

  localparam logic [PTR_W-1:0] FUSE_LOW_ADDR = 16'h0000;
  localparam logic [PTR_W-1:0] LOCK_ADDR = 16'h0001;
  localparam logic [PTR_W-1:0] FUSE_EXT_ADDR = 16'h0002;
  localparam logic [PTR_W-1:0] FUSE_HIGH_ADDR = 16'h0003;
  localparam logic [PTR_W-1:0] SIG0_ADDR = 16'h0000;
  localparam logic [PTR_W-1:0] OSC_CAL_ADDR = 16'h0001;
  localparam logic [PTR_W-1:0] SIG1_ADDR = 16'h0002;
  localparam logic [PTR_W-1:0] TS_OFFSET_ADDR = 16'h0003;
  localparam logic [PTR_W-1:0] SIG2_ADDR = 16'h0004;
  localparam logic [PTR_W-1:0] TS_GAIN_ADDR = 16'h0005;

  localparam logic [7:0] UNPROG_BYTE = 8'hff;
  localparam logic [5:0] LOCK_PAD = 6'h3f;
  localparam logic [6:0] EXT_PAD = 7'h7f;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {SFPC_IDLE, SFPC_BUSY} sfpc_state_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [CTL_W-1:0] ctl;
    logic [2:0] cnt;
    sfpc_state_t state;
    logic op_write;
    logic [PAGE_W-1:0] page;
    logic erase_req;
    logic write_req;
    logic [PAGE_WORDS-1:0] valid;
    logic rd_ok;
    logic lpm_valid;
    logic [7:0] lpm_data;
  } sfpc_regs_t;

  function automatic logic sfpc_legal(input logic [CTL_W-1:0] v);
    return (v == PAT_SIG) || (v == PAT_CLEAR_PAGE_BUFFER) || (v == PAT_FLB) ||
           (v == PAT_PW) || (v == PAT_PE) || (v == PAT_EN);
  endfunction
endpackage
`default_nettype wire

// file: sfpc_page_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module sfpc_page_buffer import sfpc_pkg::*; (
  input wire logic aclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [WADDR_W-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [WADDR_W-1:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [PAGE_WORDS];

  // Word storage only; which words hold data is tracked by the controller.
  always_ff @(posedge aclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// file: sfpc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfpc_flash_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic erase_req,
  input wire logic write_req,
  input wire logic [7:0] delay,
  output logic done
);
  // Counts the array busy time down and ends each operation with a one-cycle pulse.
  logic [7:0] left;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= (left == 8'h01);
      if (erase_req || write_req) begin
        left <= delay;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_self_program_flash_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_self_program_flash_control import sfpc_pkg::*; ;
  // Identity bytes; the values are arbitrary.
  localparam logic [7:0] SIG0 = 8'h4c;
  localparam logic [7:0] SIG1 = 8'h95;
  localparam logic [7:0] SIG2 = 8'h1e;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic spm_strobe = 1'b0, lpm_strobe = 1'b0, eeprom_write_busy = 1'b0;
  logic [15:0] ptr = 16'h0000, store_data = 16'h0000;
  logic [7:0] fuse_low_byte = 8'h00, fuse_high_byte = 8'h00, flash_delay = 8'h02;
  logic fuse_extended_byte = 1'b0, lock_bit_one = 1'b0, lock_bit_two = 1'b0;
  logic [7:0] osc_cal_byte = 8'h6b, temp_sensor_offset = 8'h81, temp_sensor_gain = 8'h3c;
  logic [WADDR_W-1:0] buf_rd_addr = 6'h00;
  logic lpm_special, cpu_stall, flash_erase_req, flash_write_req, flash_done;
  logic [7:0] lpm_data;
  logic [PAGE_W-1:0] flash_page;
  logic [15:0] buf_rd_data;
  logic [7:0] sexp [7];
  logic [7:0] fexp [4];
  logic [5:0] modes [5];
  int fail_count = 0, check_count = 0;
  always #4 aclk = ~aclk;
  sfpc_control #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) DUT (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .spm_strobe, .lpm_strobe, .pointer_high_byte(ptr[15:8]), .pointer_low_byte(ptr[7:0]),
    .store_data, .lpm_special, .lpm_data, .cpu_stall, .eeprom_write_busy, .fuse_low_byte,
    .fuse_high_byte, .fuse_extended_byte, .lock_bit_one, .lock_bit_two, .osc_cal_byte,
    .temp_sensor_offset, .temp_sensor_gain, .flash_erase_req, .flash_write_req, .flash_page,
    .flash_done, .buf_rd_addr, .buf_rd_data);
  sfpc_flash_model u_flash (.aclk, .aresetn, .erase_req(flash_erase_req),
    .write_req(flash_write_req), .delay(flash_delay), .done(flash_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    chk(bresp, (a == CTL_ADDR) ? RESP_OKAY : RESP_SLVERR);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    chk(rresp, (a == CTL_ADDR) ? RESP_OKAY : RESP_SLVERR);
  endtask
  task automatic cchk(input logic [7:0] exp);
    logic [31:0] d;
    rd(CTL_ADDR, d);
    chk(d, {24'h000000, exp});
  endtask
  task automatic spm(output logic er, output logic wq);
    spm_strobe <= 1'b1;
    @(posedge aclk);
    spm_strobe <= 1'b0;
    @(posedge aclk);
    er = flash_erase_req;
    wq = flash_write_req;
  endtask
  task automatic lpm(output logic sp, output logic [7:0] d);
    lpm_strobe <= 1'b1;
    @(posedge aclk);
    lpm_strobe <= 1'b0;
    @(posedge aclk);
    sp = lpm_special;
    d = lpm_data;
  endtask
  task automatic bchk(input logic [WADDR_W-1:0] a, input logic [15:0] exp);
    buf_rd_addr <= a;
    repeat (2) @(posedge aclk);
    chk(buf_rd_data, exp);
  endtask
  task automatic load(input logic [15:0] p, input logic [15:0] v);
    logic a;
    logic b;
    ptr <= p;
    store_data <= v;
    wr(CTL_ADDR, {2'b00, PAT_EN});
    spm(a, b);
    chk({a, b}, 2'b00);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end
  initial begin
    logic [31:0] d;
    logic sp;
    logic a;
    logic b;
    logic [7:0] v;
    logic [7:0] inv;
    sexp = '{SIG0, 8'h6b, SIG1, 8'h81, SIG2, 8'h3c, RESERVED_BYTE};
    modes = '{PAT_SIG, PAT_FLB, PAT_PE, PAT_PW, PAT_EN};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cchk(8'h00);
    rd(8'h04, d);
    chk(d, 32'h0);
    for (int p = 0; p < 2; p++) begin
      inv = p[0] ? 8'hff : 8'h00;
      fuse_low_byte <= 8'h5a ^ inv;
      fuse_high_byte <= 8'hc3 ^ inv;
      fuse_extended_byte <= p[0];
      lock_bit_one <= p[0];
      lock_bit_two <= ~p[0];
      fexp = '{8'h5a ^ inv, {LOCK_PAD, ~p[0], p[0]}, {EXT_PAD, p[0]}, 8'hc3 ^ inv};
      for (int z = 0; z < 4; z++) begin
        ptr <= z[15:0];
        wr(CTL_ADDR, {2'b00, PAT_FLB});
        lpm(sp, v);
        chk(sp, 1'b1);
        chk(v, fexp[z]);
      end
    end
    wr(CTL_ADDR, {2'b00, PAT_FLB});
    ce <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(awready, 1'b0);
    ce <= 1'b1;
    lpm(sp, v);
    chk(sp, 1'b1);
    chk(v, 8'hc3 ^ inv);
    cchk(8'h00);
    for (int z = 0; z < 7; z++) begin
      ptr <= z[15:0];
      wr(CTL_ADDR, {2'b00, PAT_SIG});
      lpm(sp, v);
      chk(sp, 1'b1);
      chk(v, sexp[z]);
    end
    cchk(8'h00);
    ptr <= 16'h0081;
    store_data <= 16'h1234;
    for (int m = 0; m < 5; m++) begin
      wr(CTL_ADDR, {2'b00, modes[m]});
      cchk({2'b00, modes[m]});
      lpm(sp, v);
      chk(sp, 1'b0);
      spm(a, b);
      chk({a, b}, 2'b00);
      cchk(8'h00);
    end
    bchk(6'h00, ERASED_WORD);
    for (int i = 0; i < 4; i++) begin
      wr(CTL_ADDR, (i == 0) ? 8'h07 : (i == 1) ? 8'h2b : (i == 2) ? 8'h19 : 8'h3f);
      cchk(8'h00);
    end
    wstrb <= 4'h0;
    wr(CTL_ADDR, {2'b00, PAT_SIG});
    wstrb <= 4'h1;
    cchk(8'h00);
    wr(8'h04, {2'b00, PAT_SIG});
    cchk(8'h00);
    ptr <= 16'h0000;
    wr(CTL_ADDR, {2'b00, PAT_FLB});
    eeprom_write_busy <= 1'b1;
    lpm(sp, v);
    chk(sp, 1'b0);
    eeprom_write_busy <= 1'b1;
    load(16'h0108, 16'h5555);
    bchk(6'h04, ERASED_WORD);
    wr(CTL_ADDR, {2'b00, PAT_FLB});
    lpm(sp, v);
    chk(sp, 1'b0);
    wr(CTL_ADDR, {2'b00, PAT_PW});
    spm(a, b);
    chk({a, b}, 2'b00);
    eeprom_write_busy <= 1'b0;
    load(16'h0105, 16'hbeef);
    bchk(6'h02, 16'hbeef);
    ptr <= 16'h0106;
    store_data <= 16'h1111;
    wr(CTL_ADDR, {2'b00, PAT_SIG});
    spm(a, b);
    chk({a, b}, 2'b00);
    bchk(6'h03, ERASED_WORD);
    load(16'h0106, 16'hcafe);
    wr(CTL_ADDR, {2'b00, PAT_CLEAR_PAGE_BUFFER});
    bchk(6'h02, ERASED_WORD);
    bchk(6'h03, ERASED_WORD);
    load(16'h0104, 16'h0bad);
    ptr <= 16'h0105;
    wr(CTL_ADDR, {2'b00, PAT_PE});
    spm(a, b);
    chk({a, b}, 2'b10);
    chk(flash_page, 32'h2);
    chk(cpu_stall, 1'b1);
    do @(posedge aclk); while (cpu_stall);
    cchk(8'h00);
    bchk(6'h02, 16'h0bad);
    flash_delay <= 8'h28;
    ptr <= 16'h0100;
    wr(CTL_ADDR, {2'b00, PAT_PW});
    spm(a, b);
    chk({a, b}, 2'b01);
    chk(flash_page, 32'h2);
    cchk({2'b00, PAT_PW});
    chk(cpu_stall, 1'b1);
    do @(posedge aclk); while (cpu_stall);
    cchk(8'h00);
    bchk(6'h02, ERASED_WORD);
    results();
  end
endmodule
`default_nettype wire
